// file: hdl/muh_pkg.sv
// Constants, types and the host register map shared by both link ends.
package muh_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int BIT_PERIOD_US = 32;
   localparam int BIT_CYC = BIT_PERIOD_US * 1000 / CLK_PERIOD_NS;
   localparam logic [11:0] BIT_RELOAD = 12'(BIT_CYC - 1);
   localparam logic [11:0] HALF_RELOAD = 12'(BIT_CYC / 2 - 1);
   localparam logic [11:0] CNT_ZERO = 12'h000;
   localparam logic [3:0] FRAME_LAST = 4'h9;
   localparam logic [3:0] START_IDX = 4'h0;
   localparam logic [3:0] BIT_ZERO = 4'h0;
   localparam int FIFO_DEPTH = 16;
   localparam logic [4:0] FIFO_FULL = 5'h10;
   localparam logic [4:0] CNT_EMPTY = 5'h00;
   localparam logic [3:0] PTR_ZERO = 4'h0;
   localparam logic [7:0] CMD_RESET = 8'hFF;
   localparam logic [7:0] CMD_PASS = 8'h3F;
   localparam logic [7:0] ACK_BYTE = 8'hFE;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h80;
   localparam logic [5:0] STATUS_RSVD = 6'h00;
   localparam logic [7:0] CFG_BASE_HI = 8'h60;
   localparam logic [7:0] CFG_BASE_LO = 8'h61;
   localparam logic [7:0] CFG_ACTIVATE = 8'h30;
   localparam int ACT_BIT = 0;
   localparam logic PORT_DATA = 1'b0;
   localparam logic PORT_CMD = 1'b1;
   localparam logic LINE_IDLE = 1'b1;
   localparam logic [15:0] ADDR_ZERO = 16'h0000;
   localparam logic [3:0] HREG_ADDR_LO = 4'h0;
   localparam logic [3:0] HREG_ADDR_HI = 4'h1;
   localparam logic [3:0] HREG_IO_WR = 4'h2;
   localparam logic [3:0] HREG_IO_RD = 4'h3;
   localparam logic [3:0] HREG_RESULT = 4'h4;
   localparam logic [3:0] HREG_STATUS = 4'h5;
   localparam logic [3:0] HREG_CFG_IDX = 4'h6;
   localparam logic [3:0] HREG_CFG_DATA = 4'h7;
   typedef enum logic {TX_IDLE, TX_SHIFT} muh_tx_st_t;
   typedef enum logic {RX_IDLE, RX_RUN} muh_rx_st_t;
endpackage

// file: hdl/muh_io_if.sv
// Host I/O and configuration link between the controller and the device.
`timescale 1ns/1ns
interface muh_io_if;
   logic [15:0] io_addr;
   logic [7:0] io_wdata;
   logic io_wr;
   logic io_rd;
   logic [7:0] io_rdata;
   logic irq;
   logic cfg_wr;
   logic [7:0] cfg_index;
   logic [7:0] cfg_wdata;
   modport dev (
      input io_addr, io_wdata, io_wr, io_rd, cfg_wr, cfg_index, cfg_wdata,
      output io_rdata, irq
   );
   modport host (
      output io_addr, io_wdata, io_wr, io_rd, cfg_wr, cfg_index, cfg_wdata,
      input io_rdata, irq
   );
endinterface

// file: hdl/muh_midi_dev.sv
// MIDI host interface device: port decode, command controller and UART.
`timescale 1ns/1ns
module muh_midi_dev
   import muh_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   muh_io_if.dev bus,
   input wire logic midi_rx_i,
   output logic midi_tx_o
);
   logic act_r, act_nxt, mode_r, mode_nxt, en_r, en_nxt;
   logic ack_r, ack_nxt, busy_r, busy_nxt;
   logic [7:0] base_hi_r, base_hi_nxt, base_lo_r, base_lo_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic [7:0] tx_mem [FIFO_DEPTH];
   logic [7:0] rx_mem [FIFO_DEPTH];
   logic [3:0] tx_wp_r, tx_wp_nxt, tx_rp_r, tx_rp_nxt;
   logic [3:0] rx_wp_r, rx_wp_nxt, rx_rp_r, rx_rp_nxt;
   logic [4:0] tx_cnt_r, tx_cnt_nxt, rx_cnt_r, rx_cnt_nxt;
   muh_tx_st_t tx_st_r, tx_st_nxt;
   muh_rx_st_t rx_st_r, rx_st_nxt;
   logic [9:0] tx_sh_r, tx_sh_nxt;
   logic [3:0] tx_bit_r, tx_bit_nxt, rx_bit_r, rx_bit_nxt;
   logic [11:0] tx_tmr_r, tx_tmr_nxt, rx_tmr_r, rx_tmr_nxt;
   logic [7:0] rx_sh_r, rx_sh_nxt;
   logic tx_line_r, tx_line_nxt, rx_q_r;
   logic [15:0] base;
   logic hit, data_wr, cmd_wr, data_rd, stat_rd;
   logic rbe, tx_busy, tx_push, tx_pop, rx_push, rx_pop;
   logic do_reset, do_pass, flush_rx, flush_tx, set_ack, run;
   logic [7:0] status;

   assign base = {base_hi_r, base_lo_r[7:1], 1'b0};
   assign hit = act_r && (bus.io_addr[15:1] == base[15:1]);
   assign data_wr = hit && bus.io_wr && (bus.io_addr[0] == PORT_DATA);
   assign cmd_wr = hit && bus.io_wr && (bus.io_addr[0] == PORT_CMD);
   assign data_rd = hit && bus.io_rd && (bus.io_addr[0] == PORT_DATA);
   assign stat_rd = hit && bus.io_rd && (bus.io_addr[0] == PORT_CMD);
   assign rbe = !(ack_r || (rx_cnt_r != CNT_EMPTY));
   assign tx_busy = (tx_cnt_r == FIFO_FULL) || busy_r;
   assign status = {rbe, tx_busy, STATUS_RSVD};
   // Commands arriving while busy are dropped like data writes.
   assign do_reset = cmd_wr && !busy_r && (bus.io_wdata == CMD_RESET);
   assign do_pass = cmd_wr && !busy_r && !mode_r
      && (bus.io_wdata == CMD_PASS);
   assign flush_rx = do_reset || do_pass;
   assign flush_tx = do_reset || do_pass;
   assign set_ack = do_pass || (do_reset && !mode_r);
   assign tx_push = data_wr && en_r && mode_r && !tx_busy;
   assign rx_pop = data_rd && !ack_r && (rx_cnt_r != CNT_EMPTY);
   assign run = act_r;
   assign bus.irq = act_r && !rbe;
   assign midi_tx_o = tx_line_r;

   always_comb
   begin
      act_nxt = act_r;
      base_hi_nxt = base_hi_r;
      base_lo_nxt = base_lo_r;
      if (bus.cfg_wr)
      begin
         if (bus.cfg_index == CFG_ACTIVATE)
            act_nxt = bus.cfg_wdata[ACT_BIT];
         else if (bus.cfg_index == CFG_BASE_HI)
            base_hi_nxt = bus.cfg_wdata;
         else if (bus.cfg_index == CFG_BASE_LO)
            base_lo_nxt = {bus.cfg_wdata[7:1], 1'b0};
      end
      // Reset and mode codes differ, so at most one of them fires.
      mode_nxt = do_pass || (mode_r && !do_reset);
      en_nxt = do_pass || (en_r && !do_reset);
      busy_nxt = do_reset || do_pass;
      // The set of a new acknowledge beats the clear from a read.
      ack_nxt = set_ack || (ack_r && !data_rd);
      rdata_nxt = rdata_r;
      if (data_rd)
      begin
         if (ack_r)
            rdata_nxt = ACK_BYTE;
         else if (rx_cnt_r != CNT_EMPTY)
            rdata_nxt = rx_mem[rx_rp_r];
         else
            rdata_nxt = BYTE_ZERO;
      end
      else if (stat_rd)
         rdata_nxt = status;
   end

   always_comb
   begin
      tx_st_nxt = tx_st_r;
      tx_sh_nxt = tx_sh_r;
      tx_bit_nxt = tx_bit_r;
      tx_tmr_nxt = tx_tmr_r;
      tx_pop = 1'b0;
      case (tx_st_r)
         TX_IDLE:
         begin
            if (run && en_r && !flush_tx && (tx_cnt_r != CNT_EMPTY))
            begin
               tx_pop = 1'b1;
               tx_sh_nxt = {LINE_IDLE, tx_mem[tx_rp_r], 1'b0};
               tx_bit_nxt = BIT_ZERO;
               tx_tmr_nxt = BIT_RELOAD;
               tx_st_nxt = TX_SHIFT;
            end
         end
         TX_SHIFT:
         begin
            if (tx_tmr_r != CNT_ZERO)
               tx_tmr_nxt = tx_tmr_r - 12'h001;
            else if (tx_bit_r == FRAME_LAST)
               tx_st_nxt = TX_IDLE;
            else
            begin
               tx_sh_nxt = {LINE_IDLE, tx_sh_r[9:1]};
               tx_bit_nxt = tx_bit_r + 4'h1;
               tx_tmr_nxt = BIT_RELOAD;
            end
         end
         default:
            tx_st_nxt = TX_IDLE;
      endcase
      tx_line_nxt = (tx_st_nxt == TX_SHIFT) ? tx_sh_nxt[0] : LINE_IDLE;
   end

   always_comb
   begin
      rx_st_nxt = rx_st_r;
      rx_sh_nxt = rx_sh_r;
      rx_bit_nxt = rx_bit_r;
      rx_tmr_nxt = rx_tmr_r;
      rx_push = 1'b0;
      case (rx_st_r)
         RX_IDLE:
         begin
            if (run && en_r && (rx_q_r == 1'b0))
            begin
               // Sampling in mid-bit tolerates the one percent rate skew.
               rx_tmr_nxt = HALF_RELOAD;
               rx_bit_nxt = START_IDX;
               rx_st_nxt = RX_RUN;
            end
         end
         RX_RUN:
         begin
            if (rx_tmr_r != CNT_ZERO)
               rx_tmr_nxt = rx_tmr_r - 12'h001;
            else
            begin
               rx_tmr_nxt = BIT_RELOAD;
               rx_bit_nxt = rx_bit_r + 4'h1;
               if (rx_bit_r == START_IDX)
               begin
                  if (rx_q_r == LINE_IDLE)
                     rx_st_nxt = RX_IDLE;
               end
               else if (rx_bit_r == FRAME_LAST)
               begin
                  rx_st_nxt = RX_IDLE;
                  // A frame without a stop bit or with the FIFO full is lost.
                  rx_push = (rx_q_r == LINE_IDLE) && en_r
                     && (rx_cnt_r != FIFO_FULL);
               end
               else
                  rx_sh_nxt = {rx_q_r, rx_sh_r[7:1]};
            end
         end
         default:
            rx_st_nxt = RX_IDLE;
      endcase
   end

   always_comb
   begin
      if (flush_tx)
      begin
         tx_wp_nxt = PTR_ZERO;
         tx_rp_nxt = PTR_ZERO;
         tx_cnt_nxt = CNT_EMPTY;
      end
      else
      begin
         tx_wp_nxt = tx_wp_r + {3'h0, tx_push};
         tx_rp_nxt = tx_rp_r + {3'h0, tx_pop};
         tx_cnt_nxt = tx_cnt_r + {4'h0, tx_push} - {4'h0, tx_pop};
      end
      if (flush_rx)
      begin
         rx_wp_nxt = PTR_ZERO;
         rx_rp_nxt = PTR_ZERO;
         rx_cnt_nxt = CNT_EMPTY;
      end
      else
      begin
         rx_wp_nxt = rx_wp_r + {3'h0, rx_push};
         rx_rp_nxt = rx_rp_r + {3'h0, rx_pop};
         rx_cnt_nxt = rx_cnt_r + {4'h0, rx_push} - {4'h0, rx_pop};
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (tx_push)
         tx_mem[tx_wp_r] <= bus.io_wdata;
      if (rx_push && !flush_rx)
         rx_mem[rx_wp_r] <= rx_sh_r;
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         act_r <= 1'b0;
         base_hi_r <= BYTE_ZERO;
         base_lo_r <= BYTE_ZERO;
         mode_r <= 1'b0;
         en_r <= 1'b0;
         ack_r <= 1'b0;
         busy_r <= 1'b0;
         rdata_r <= STATUS_RESET;
         tx_wp_r <= PTR_ZERO;
         tx_rp_r <= PTR_ZERO;
         tx_cnt_r <= CNT_EMPTY;
         rx_wp_r <= PTR_ZERO;
         rx_rp_r <= PTR_ZERO;
         rx_cnt_r <= CNT_EMPTY;
         tx_st_r <= TX_IDLE;
         tx_sh_r <= 10'h3FF;
         tx_bit_r <= BIT_ZERO;
         tx_tmr_r <= CNT_ZERO;
         tx_line_r <= LINE_IDLE;
         rx_st_r <= RX_IDLE;
         rx_sh_r <= BYTE_ZERO;
         rx_bit_r <= BIT_ZERO;
         rx_tmr_r <= CNT_ZERO;
         rx_q_r <= LINE_IDLE;
      end
      else
      begin
         act_r <= act_nxt;
         base_hi_r <= base_hi_nxt;
         base_lo_r <= base_lo_nxt;
         mode_r <= mode_nxt;
         en_r <= en_nxt;
         ack_r <= ack_nxt;
         busy_r <= busy_nxt;
         rdata_r <= rdata_nxt;
         tx_wp_r <= tx_wp_nxt;
         tx_rp_r <= tx_rp_nxt;
         tx_cnt_r <= tx_cnt_nxt;
         rx_wp_r <= rx_wp_nxt;
         rx_rp_r <= rx_rp_nxt;
         rx_cnt_r <= rx_cnt_nxt;
         tx_st_r <= tx_st_nxt;
         tx_sh_r <= tx_sh_nxt;
         tx_bit_r <= tx_bit_nxt;
         tx_tmr_r <= tx_tmr_nxt;
         tx_line_r <= tx_line_nxt;
         rx_st_r <= rx_st_nxt;
         rx_sh_r <= rx_sh_nxt;
         rx_bit_r <= rx_bit_nxt;
         rx_tmr_r <= rx_tmr_nxt;
         rx_q_r <= midi_rx_i;
      end
   end

   assign bus.io_rdata = rdata_r;
endmodule

// file: hdl/muh_midi_host.sv
// Host end: turns register orders into I/O and configuration cycles.
`timescale 1ns/1ns
module muh_midi_host
   import muh_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   muh_io_if.host bus,
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o
);
   logic [15:0] addr_r, addr_nxt;
   logic [7:0] wdata_r, wdata_nxt, cidx_r, cidx_nxt, cdat_r, cdat_nxt;
   logic wr_r, wr_nxt, rd_r, rd_nxt, cwr_r, cwr_nxt;
   logic pend_r, pend_nxt, valid_r, valid_nxt;
   logic [7:0] result_r, result_nxt, rdata_r, rdata_nxt;

   always_comb
   begin
      addr_nxt = addr_r;
      wdata_nxt = wdata_r;
      cidx_nxt = cidx_r;
      cdat_nxt = cdat_r;
      wr_nxt = 1'b0;
      rd_nxt = 1'b0;
      cwr_nxt = 1'b0;
      if (reg_wr_i)
      begin
         case (reg_addr_i)
            HREG_ADDR_LO: addr_nxt = {addr_r[15:8], reg_wdata_i};
            HREG_ADDR_HI: addr_nxt = {reg_wdata_i, addr_r[7:0]};
            HREG_IO_WR:
            begin
               wdata_nxt = reg_wdata_i;
               wr_nxt = 1'b1;
            end
            HREG_IO_RD: rd_nxt = 1'b1;
            HREG_CFG_IDX: cidx_nxt = reg_wdata_i;
            HREG_CFG_DATA:
            begin
               // The device also clears bit 0 of the low base byte; it is cleared here too.
               if (cidx_r == CFG_BASE_LO)
                  cdat_nxt = {reg_wdata_i[7:1], 1'b0};
               else
                  cdat_nxt = reg_wdata_i;
               cwr_nxt = 1'b1;
            end
            default: addr_nxt = addr_r;
         endcase
      end
      pend_nxt = rd_r;
      result_nxt = pend_r ? bus.io_rdata : result_r;
      if (pend_r)
         valid_nxt = 1'b1;
      else if (reg_rd_i && (reg_addr_i == HREG_RESULT))
         valid_nxt = 1'b0;
      else
         valid_nxt = valid_r;
      rdata_nxt = BYTE_ZERO;
      if (reg_rd_i)
      begin
         case (reg_addr_i)
            HREG_ADDR_LO: rdata_nxt = addr_r[7:0];
            HREG_ADDR_HI: rdata_nxt = addr_r[15:8];
            HREG_RESULT: rdata_nxt = result_r;
            HREG_STATUS: rdata_nxt = {5'h00, pend_r || rd_r, valid_r, bus.irq};
            HREG_CFG_IDX: rdata_nxt = cidx_r;
            default: rdata_nxt = BYTE_ZERO;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         addr_r <= ADDR_ZERO;
         wdata_r <= BYTE_ZERO;
         cidx_r <= BYTE_ZERO;
         cdat_r <= BYTE_ZERO;
         wr_r <= 1'b0;
         rd_r <= 1'b0;
         cwr_r <= 1'b0;
         pend_r <= 1'b0;
         valid_r <= 1'b0;
         result_r <= BYTE_ZERO;
         rdata_r <= BYTE_ZERO;
      end
      else
      begin
         addr_r <= addr_nxt;
         wdata_r <= wdata_nxt;
         cidx_r <= cidx_nxt;
         cdat_r <= cdat_nxt;
         wr_r <= wr_nxt;
         rd_r <= rd_nxt;
         cwr_r <= cwr_nxt;
         pend_r <= pend_nxt;
         valid_r <= valid_nxt;
         result_r <= result_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign bus.io_addr = addr_r;
   assign bus.io_wdata = wdata_r;
   assign bus.io_wr = wr_r;
   assign bus.io_rd = rd_r;
   assign bus.cfg_wr = cwr_r;
   assign bus.cfg_index = cidx_r;
   assign bus.cfg_wdata = cdat_r;
   assign reg_rdata_o = rdata_r;
endmodule

// file: tb/muh_link_sva.sv
// Assertion checker watching the link between host end and device end.
`timescale 1ns/1ns
module muh_link_sva
   import muh_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic [15:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_rdata,
   input wire logic irq,
   input wire logic cfg_wr,
   input wire logic [7:0] cfg_index,
   input wire logic [7:0] cfg_wdata
);
   logic act_r, act_nxt, mode_r, mode_nxt, hit, acc;
   logic [15:0] base_r, base_nxt;
   // A shadow of activate, base and mode, rebuilt from the link traffic.
   assign hit = act_r && (io_addr[15:1] == base_r[15:1]);
   assign acc = io_wr && hit && io_addr[0];
   always_comb
   begin
      act_nxt = act_r;
      base_nxt = base_r;
      mode_nxt = mode_r;
      if (cfg_wr && cfg_index == CFG_ACTIVATE)
         act_nxt = cfg_wdata[ACT_BIT];
      if (cfg_wr && cfg_index == CFG_BASE_HI)
         base_nxt[15:8] = cfg_wdata;
      if (cfg_wr && cfg_index == CFG_BASE_LO)
         base_nxt[7:0] = {cfg_wdata[7:1], 1'b0};
      if (acc && io_wdata == CMD_PASS)
         mode_nxt = 1'b1;
      if (acc && io_wdata == CMD_RESET)
         mode_nxt = 1'b0;
   end
   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         act_r <= 1'b0;
         base_r <= ADDR_ZERO;
         mode_r <= 1'b0;
      end
      else
      begin
         act_r <= act_nxt;
         base_r <= base_nxt;
         mode_r <= mode_nxt;
      end
   end
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_b_i);
   quiet_idle_a: assert property (!act_r |-> !irq)
      else $error("interrupt high while inactive");
   stale_read_a: assert property (io_rd && !act_r
      |=> $stable(io_rdata))
      else $error("read data changed while inactive");
   pass_ack_a: assert property (acc && io_wdata == CMD_PASS && !mode_r
      |=> irq) else $error("no acknowledge after mode command");
   reset_ack_a: assert property (acc && io_wdata == CMD_RESET
      && !mode_r |=> irq) else $error("no acknowledge after reset command");
   pass_once_a: assert property (acc && io_wdata == CMD_PASS && mode_r
      && !irq |=> !irq) else $error("repeated mode command acted");
   reset_quiet_a: assert property (acc && io_wdata == CMD_RESET
      && mode_r |=> !irq) else $error("reset in mode left data readable");
   odd_code_a: assert property (acc && io_wdata != CMD_PASS
      && io_wdata != CMD_RESET && !irq |=> !irq)
      else $error("unknown command had an effect");
   status_bits_a: assert property (io_rd && hit && io_addr[0]
      |=> io_rdata[7] == !$past(irq) && io_rdata[5:0] == STATUS_RSVD)
      else $error("status byte wrong");
   ack_first_a: assert property (acc && io_wdata == CMD_PASS && !mode_r
      ##[1:6] (io_rd && hit && !io_addr[0]) |=> io_rdata == ACK_BYTE)
      else $error("first data read was not the acknowledge");
   cover property (acc && io_wdata == CMD_PASS && !mode_r);
   cover property (acc && io_wdata == CMD_RESET && mode_r);
   cover property (io_rd && hit && !io_addr[0] && irq);
endmodule

// file: tb/testbench.sv
// Self-checking bench for the joined host end and MIDI device end.
`timescale 1ns/1ns
module testbench
   import muh_pkg::*;
;
   localparam logic [15:0] DATA = 16'h0130;
   localparam logic [15:0] CMD = 16'h0131;
   logic ref_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic midi_rx = 1'b1;
   logic midi_tx;
   logic [7:0] got;
   int num_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   muh_io_if bus_if();
   muh_midi_host i_muh_midi_host (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
      .bus(bus_if.host), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
      .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata));
   muh_midi_dev i_muh_midi_dev (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
      .bus(bus_if.dev), .midi_rx_i(midi_rx), .midi_tx_o(midi_tx));
   muh_link_sva i_muh_link_sva (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
      .io_addr(bus_if.io_addr), .io_wdata(bus_if.io_wdata),
      .io_wr(bus_if.io_wr), .io_rd(bus_if.io_rd),
      .io_rdata(bus_if.io_rdata), .irq(bus_if.irq), .cfg_wr(bus_if.cfg_wr),
      .cfg_index(bus_if.cfg_index), .cfg_wdata(bus_if.cfg_wdata));
   always #5 ref_clk_i = ~ref_clk_i;
   task automatic test_done();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Two serial frames dominate the run, so the ceiling sits about a fifth above.
   always @(posedge ref_clk_i)
   begin
      cycles++;
      if (cycles == 80000)
      begin
         num_errors++;
         $display("unexpected at %0t: run did not finish", $time);
         test_done();
      end
   end
   task automatic check(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic r, input logic [3:0] a,
      input logic [7:0] d);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk_i);
   endtask
   // Read data stand only in the cycle after the strobe, so sample there.
   task automatic rd_reg(input logic [3:0] a);
      bus(1'b0, 1'b1, a, 8'h00);
      bus(1'b0, 1'b0, 4'h0, 8'h00);
      got = reg_rdata;
   endtask
   task automatic set_addr(input logic [15:0] a);
      bus(1'b1, 1'b0, HREG_ADDR_LO, a[7:0]);
      bus(1'b1, 1'b0, HREG_ADDR_HI, a[15:8]);
   endtask
   task automatic io_write(input logic [15:0] a, input logic [7:0] d);
      set_addr(a);
      bus(1'b1, 1'b0, HREG_IO_WR, d);
      bus(1'b0, 1'b0, 4'h0, 8'h00);
   endtask
   task automatic io_read(input logic [15:0] a, input logic [7:0] e);
      set_addr(a);
      bus(1'b1, 1'b0, HREG_IO_RD, 8'h00);
      bus(1'b0, 1'b0, 4'h0, 8'h00);
      bus(1'b0, 1'b0, 4'h0, 8'h00);
      rd_reg(HREG_RESULT);
      check(got, e);
   endtask
   task automatic irq_is(input logic e);
      rd_reg(HREG_STATUS);
      check({7'h00, got[0]}, {7'h00, e});
   endtask
   task automatic cfg(input logic [7:0] idx, input logic [7:0] d);
      bus(1'b1, 1'b0, HREG_CFG_IDX, idx);
      bus(1'b1, 1'b0, HREG_CFG_DATA, d);
   endtask
   task automatic send_rx(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         midi_rx <= f[i];
         repeat (BIT_CYC) @(posedge ref_clk_i);
      end
   endtask
   task automatic watch_tx(input logic [7:0] e);
      logic [9:0] f;
      int n;
      n = 0;
      while (midi_tx === LINE_IDLE && n < 100)
      begin
         @(posedge ref_clk_i);
         n++;
      end
      repeat (BIT_CYC / 2) @(posedge ref_clk_i);
      for (int i = 0; i < 10; i++)
      begin
         f[i] = midi_tx;
         repeat (BIT_CYC) @(posedge ref_clk_i);
      end
      check(f[8:1], e);
      check({6'h00, f[9], f[0]}, 8'h02);
   endtask
   task automatic t_idle();
      io_write(16'h0001, CMD_RESET);
      irq_is(1'b0);
      io_read(16'h0000, STATUS_RESET);
      rd_reg(4'hF);
      check(got, 8'h00);
   endtask
   task automatic t_config();
      cfg(CFG_BASE_HI, 8'h01);
      cfg(CFG_BASE_LO, 8'h31);
      cfg(CFG_ACTIVATE, 8'h01);
      io_read(CMD, STATUS_RESET);
   endtask
   task automatic t_reset_cmd();
      io_write(CMD, CMD_RESET);
      irq_is(1'b1);
      cfg(CFG_ACTIVATE, 8'h00);
      bus(1'b0, 1'b0, 4'h0, 8'h00);
      irq_is(1'b0);
      cfg(CFG_ACTIVATE, 8'h01);
      io_read(CMD, 8'h00);
      io_read(DATA, ACK_BYTE);
      irq_is(1'b0);
      io_write(CMD, 8'h55);
      irq_is(1'b0);
   endtask
   task automatic t_pass();
      io_write(CMD, CMD_PASS);
      io_read(DATA, ACK_BYTE);
      irq_is(1'b0);
      io_write(CMD, CMD_PASS);
      irq_is(1'b0);
   endtask
   // Receive two bytes while one byte goes out, all at the bit rate.
   task automatic t_duplex();
      fork
         begin
            send_rx(8'hA5);
            send_rx(8'h5A);
         end
         begin
            io_write(DATA, 8'h3C);
            watch_tx(8'h3C);
         end
      join
      repeat (BIT_CYC) @(posedge ref_clk_i);
      irq_is(1'b1);
      io_read(DATA, 8'hA5);
      irq_is(1'b1);
      io_write(CMD, CMD_RESET);
      irq_is(1'b0);
      io_read(CMD, STATUS_RESET);
      io_read(DATA, 8'h00);
   endtask
   // Sixteen bytes queue behind the one on the line, so the queue is full.
   task automatic t_busy();
      io_write(CMD, CMD_PASS);
      io_read(DATA, ACK_BYTE);
      for (int i = 0; i < 17; i++)
         io_write(DATA, 8'(i));
      io_read(CMD, 8'hC0);
      io_write(CMD, CMD_RESET);
      io_read(CMD, STATUS_RESET);
   endtask
   initial
   begin
      repeat (2) @(posedge ref_clk_i);
      rst_b_i <= 1'b1;
      @(posedge ref_clk_i);
      t_idle();
      t_config();
      t_reset_cmd();
      t_pass();
      t_duplex();
      t_busy();
      test_done();
   end
endmodule
